// file: design/motion_state_priority_encoder.sv
// Operating-state sequencer of the positioner, one state active at a time.
// Assumes command strobes are one-cycle and synchronous to ref_clk_i.
`timescale 1ns/1ps
module motion_state_priority_encoder
  import motion_state_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire cmd_s cmd_i,
  input wire logic [POS_W-1:0] cmd_target_i,
  input wire logic [SEC_W-1:0] cmd_secure_i,
  input wire logic cmd_secure_valid_i,
  input wire motion_par_s ram_par_i,
  input wire motion_par_s dual_par_i,
  input wire logic [1:0] dual_par_given_i,
  input wire event_s evt_i,
  input wire logic [POS_W-1:0] actual_pos_i,
  input wire logic sleep_permit_i,
  output op_state_e state_o,
  output logic [POS_W-1:0] target_pos_o,
  output motion_par_s active_par_o,
  output motion_par_s status_par_o,
  output logic sleep_flag_o,
  output logic stop_flag_o,
  output logic secure_en_o,
  output logic bridge_fault_flag_o,
  output logic thermal_flag_o,
  output logic step_loss_o,
  output logic bridges_hiz_o,
  output logic hold_current_o,
  output logic assign_ids_o,
  output logic wake_reset_o
);
  op_state_e state_r, state_nxt;
  logic [POS_W-1:0] target_r, target_nxt;
  logic [SEC_W-1:0] secure_r, secure_nxt;
  motion_par_s dual_r, dual_nxt, status_r, status_nxt;
  logic dual_shape_r, dual_shape_nxt;
  logic sleep_r, sleep_nxt, stop_r, stop_nxt;
  logic pend_sec_r, pend_sec_nxt;
  logic hs_r, hs_nxt, tsd_r, tsd_nxt, sl_r, sl_nxt;
  logic read_r, read_nxt, ids_r, ids_nxt, wake_r, wake_nxt;
  logic sec_en, sleep_req, sec_match;

  function automatic logic is_moving(input op_state_e s);
    return (s == ST_GOTO) || (s == ST_DUAL);
  endfunction

  assign sec_en = (secure_r != SEC_DISABLED);
  assign sleep_req = cmd_i.sleep_cmd | evt_i.bus_timeout;
  assign sec_match = (actual_pos_i[SEC_W-1:0] == secure_r);

  always_comb begin
    state_nxt = state_r;
    target_nxt = target_r;
    secure_nxt = secure_r;
    dual_nxt = dual_r;
    dual_shape_nxt = dual_shape_r;
    status_nxt = ram_par_i;
    sleep_nxt = sleep_r;
    stop_nxt = stop_r;
    pend_sec_nxt = pend_sec_r;
    hs_nxt = hs_r | evt_i.electrical_defect;
    tsd_nxt = tsd_r | evt_i.thermal_shutdown;
    sl_nxt = sl_r;
    read_nxt = read_r;
    ids_nxt = 1'b0;
    wake_nxt = 1'b0;
    if (cmd_i.any_cmd && !sleep_req) begin
      sleep_nxt = 1'b0;
      pend_sec_nxt = 1'b0;
    end
    if (sleep_req) begin
      sleep_nxt = 1'b1;
    end
    if (cmd_i.read_status) begin
      read_nxt = 1'b1;
      sl_nxt = 1'b0;
    end
    // Clear only after a read, and the set path still wins
    if (read_r && !evt_i.phys_fault) begin
      if (!evt_i.electrical_defect) hs_nxt = 1'b0;
      if (!evt_i.thermal_shutdown) tsd_nxt = 1'b0;
      read_nxt = 1'b0;
    end
    if (cmd_secure_valid_i) begin
      secure_nxt = cmd_secure_i;
    end
    if (cmd_i.assign_ids && state_r != ST_SLEEP) begin
      ids_nxt = 1'b1;
    end
    if (state_r == ST_STOPPED) begin
      stop_nxt = 1'b0;
    end
    unique case (state_r)
      ST_STANDBY: begin
        if (evt_i.electrical_defect || evt_i.thermal_shutdown) begin
          state_nxt = ST_SHUTDOWN;
        end else if (sleep_req) begin
          state_nxt = ST_SLEEP;
        end else if (cmd_i.any_cmd) begin
          state_nxt = ST_STOPPED;
        end
      end
      ST_STOPPED: begin
        if (evt_i.electrical_defect || evt_i.thermal_shutdown) begin
          state_nxt = ST_SHUTDOWN;
          target_nxt = actual_pos_i;
        end else if (evt_i.undervoltage_level_two) begin
          state_nxt = ST_UNDERV;
        end else if (cmd_i.dual_move) begin
          state_nxt = ST_DUAL;
          dual_nxt.vmax = dual_par_given_i[0] ? dual_par_i.vmax
                                                : ram_par_i.vmax;
          dual_nxt.vmin = dual_par_given_i[1] ? dual_par_i.vmin
                                                : ram_par_i.vmin;
          dual_nxt.accel_shape_select = ram_par_i.accel_shape_select;
          dual_shape_nxt = 1'b0;
        end else if (sleep_r && !cmd_i.any_cmd) begin
          if (!sec_en || sec_match || stop_r) begin
            if (sleep_permit_i) begin
              state_nxt = ST_SLEEP;
            end
          end else begin
            state_nxt = ST_GOTO;
            target_nxt = {{(POS_W-SEC_W){secure_r[SEC_W-1]}}, secure_r};
          end
        end else if (cmd_i.go_safe_position && sec_en) begin
          target_nxt = {{(POS_W-SEC_W){secure_r[SEC_W-1]}}, secure_r};
          state_nxt = ST_GOTO;
        end else if (cmd_i.write_target) begin
          target_nxt = cmd_target_i;
          state_nxt = ST_GOTO;
        end else if (actual_pos_i != target_r) begin
          state_nxt = ST_GOTO;
        end
      end
      ST_GOTO, ST_DUAL: begin
        if (evt_i.electrical_defect || cmd_i.forced_stop) begin
          state_nxt = ST_FORCED;
          sl_nxt = evt_i.electrical_defect | sl_r;
        end else if (evt_i.undervoltage_level_two) begin
          state_nxt = (state_r == ST_DUAL) ? ST_FORCED : ST_UNDERV;
        end else if (evt_i.thermal_shutdown || cmd_i.decelerating_stop) begin
          state_nxt = ST_DECEL;
        end else if (sleep_req && state_r == ST_GOTO) begin
          if (sec_en) begin
            target_nxt = {{(POS_W-SEC_W){secure_r[SEC_W-1]}}, secure_r};
          end else begin
            state_nxt = ST_DECEL;
          end
        end else if (sleep_req && sec_en) begin
          pend_sec_nxt = 1'b1;
        end else if (evt_i.motion_done) begin
          if (state_r == ST_DUAL && !dual_shape_r) begin
            dual_shape_nxt = 1'b1;
          end else begin
            state_nxt = ST_STOPPED;
            if (pend_sec_r) begin
              target_nxt = {{(POS_W-SEC_W){secure_r[SEC_W-1]}}, secure_r};
              pend_sec_nxt = 1'b0;
            end
          end
        end else if (state_r == ST_GOTO) begin
          if (cmd_i.write_target) target_nxt = cmd_target_i;
          else if (cmd_i.go_safe_position && sec_en) begin
            target_nxt = {{(POS_W-SEC_W){secure_r[SEC_W-1]}}, secure_r};
          end
        end
      end
      ST_DECEL, ST_FORCED, ST_UNDERV: begin
        if (state_r == ST_DECEL && (evt_i.electrical_defect ||
                                    cmd_i.forced_stop)) begin
          state_nxt = ST_FORCED;
          sl_nxt = evt_i.electrical_defect | sl_r;
        end else if (state_r == ST_DECEL &&
                     evt_i.undervoltage_level_two) begin
          state_nxt = ST_UNDERV;
        end else if (evt_i.motion_done) begin
          state_nxt = ST_STOPPED;
          target_nxt = actual_pos_i;
          stop_nxt = (state_r != ST_UNDERV);
        end
      end
      ST_SHUTDOWN: begin
        if (evt_i.bus_timeout) begin
          state_nxt = ST_SLEEP;
        end else if (cmd_i.read_status && !hs_r && !tsd_r &&
                     !evt_i.phys_fault && !evt_i.electrical_defect &&
                     !evt_i.thermal_shutdown) begin
          state_nxt = ST_STOPPED;
        end
      end
      ST_SLEEP: begin
        if (cmd_i.any_cmd) begin
          wake_nxt = 1'b1;
        end
      end
      default: state_nxt = ST_STANDBY;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= ST_STANDBY;
      target_r <= POS_RESET;
      secure_r <= SEC_RESET;
      dual_r <= '0;
      dual_shape_r <= 1'b0;
      status_r <= '0;
      sleep_r <= 1'b0;
      stop_r <= 1'b0;
      pend_sec_r <= 1'b0;
      hs_r <= 1'b0;
      tsd_r <= 1'b0;
      sl_r <= 1'b0;
      read_r <= 1'b0;
      ids_r <= 1'b0;
      wake_r <= 1'b0;
    end else if (wake_r) begin
      // Wake is a full restart of all state, same as power-on
      state_r <= ST_STANDBY;
      target_r <= POS_RESET;
      secure_r <= SEC_RESET;
      dual_r <= '0;
      dual_shape_r <= 1'b0;
      status_r <= '0;
      sleep_r <= 1'b0;
      stop_r <= 1'b0;
      pend_sec_r <= 1'b0;
      hs_r <= 1'b0;
      tsd_r <= 1'b0;
      sl_r <= 1'b0;
      read_r <= 1'b0;
      ids_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      target_r <= target_nxt;
      secure_r <= secure_nxt;
      dual_r <= dual_nxt;
      dual_shape_r <= dual_shape_nxt;
      status_r <= status_nxt;
      sleep_r <= sleep_nxt;
      stop_r <= stop_nxt;
      pend_sec_r <= pend_sec_nxt;
      hs_r <= hs_nxt;
      tsd_r <= tsd_nxt;
      sl_r <= sl_nxt;
      read_r <= read_nxt;
      ids_r <= ids_nxt;
      wake_r <= wake_nxt;
    end
  end

  motion_par_s act_par_r;
  logic sec_en_r, hiz_r, hold_r;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      act_par_r <= '0;
      sec_en_r <= 1'b0;
      hiz_r <= 1'b1;
      hold_r <= 1'b0;
    end else begin
      act_par_r <= wake_r ? '0 : (state_nxt == ST_DUAL) ?
        {dual_nxt.vmax, dual_nxt.vmin,
         dual_shape_nxt | dual_nxt.accel_shape_select} : ram_par_i;
      sec_en_r <= !wake_r && (secure_nxt != SEC_DISABLED);
      hiz_r <= (state_nxt == ST_SHUTDOWN) || (state_nxt == ST_SLEEP) ||
               (state_nxt == ST_STANDBY);
      hold_r <= (state_nxt == ST_STOPPED);
    end
  end

  assign state_o = state_r;
  assign target_pos_o = target_r;
  assign active_par_o = act_par_r;
  assign status_par_o = status_r;
  assign sleep_flag_o = sleep_r;
  assign stop_flag_o = stop_r;
  assign secure_en_o = sec_en_r;
  assign bridge_fault_flag_o = hs_r;
  assign thermal_flag_o = tsd_r;
  assign step_loss_o = sl_r;
  assign bridges_hiz_o = hiz_r;
  assign hold_current_o = hold_r;
  assign assign_ids_o = ids_r;
  assign wake_reset_o = wake_r;

  chk_stop_clear: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (state_r == ST_STOPPED && !wake_r) |=> !stop_r)
    else $error("stop flag not cleared in stopped");
  chk_stop_set: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    ($past(state_r) inside {ST_DECEL, ST_FORCED} &&
      state_r == ST_STOPPED) |-> stop_r)
    else $error("stop flag not set after stop");
  chk_secure_en: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    ##1 (sec_en_r == (secure_r != SEC_DISABLED)))
    else $error("secure enable mismatch");
  chk_sleep_set: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (sleep_req && !wake_r) |=> sleep_r)
    else $error("sleep flag not set");
  chk_no_sleep: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (state_r == ST_STOPPED && !sleep_permit_i) |=> state_r != ST_SLEEP)
    else $error("sleep entered without permit");
  chk_shut_hold: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (state_r == ST_SHUTDOWN && (hs_r || tsd_r) && !wake_r)
      |=> state_r inside {ST_SHUTDOWN, ST_SLEEP})
    else $error("shutdown left with flags set");
  chk_goto_nosleep: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (state_r == ST_GOTO) |=> state_r != ST_SLEEP)
    else $error("direct sleep from move");
  chk_ids_state: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (state_r == ST_SLEEP && !wake_r) |=> !ids_r)
    else $error("ids decoded in sleep");
  chk_wake_reset: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    wake_r |=> (state_r == ST_STANDBY && !sleep_r && !hs_r))
    else $error("wake not like reset");
  chk_stop_target: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    ($past(state_r) inside {ST_DECEL, ST_FORCED} &&
      state_r == ST_STOPPED)
      |-> target_r == $past(actual_pos_i))
    else $error("target not copied on stop");
endmodule // motion_state_priority_encoder

// file: design/motion_state_pkg.sv
// Package for the positioner state sequencer: states, widths, codes.
// Assumes a single synchronous clock domain; no bus, plain ports.
package motion_state_pkg;
  localparam int POS_W = 16;
  localparam int SEC_W = 11;
  localparam logic [SEC_W-1:0] SEC_DISABLED = 11'h400;
  localparam logic [POS_W-1:0] POS_RESET = 16'h0000;
  localparam logic [SEC_W-1:0] SEC_RESET = 11'h400;
  localparam logic [7:0] VEL_RESET = 8'h00;

  typedef enum logic [3:0] {
    ST_STANDBY = 4'h0,
    ST_STOPPED = 4'h1,
    ST_GOTO = 4'h2,
    ST_DUAL = 4'h3,
    ST_DECEL = 4'h4,
    ST_FORCED = 4'h5,
    ST_UNDERV = 4'h6,
    ST_SHUTDOWN = 4'h7,
    ST_SLEEP = 4'h8
  } op_state_e;

  // One-cycle command strobes decoded by the frame layer
  typedef struct packed {
    logic any_cmd;
    logic read_status;
    logic write_target;
    logic go_safe_position;
    logic dual_move;
    logic decelerating_stop;
    logic forced_stop;
    logic sleep_cmd;
    logic write_motor_params;
    logic assign_ids;
  } cmd_s;

  typedef struct packed {
    logic [7:0] vmax;
    logic [7:0] vmin;
    logic accel_shape_select;
  } motion_par_s;

  typedef struct packed {
    logic bus_timeout;
    logic thermal_shutdown;
    logic electrical_defect;
    logic undervoltage_level_two;
    logic phys_fault;
    logic motion_done;
  } event_s;
endpackage

// file: verification/lin_master_model.sv
// Bus master model: issues one-cycle command strobes, holds working memory.
// Assumes the device samples every strobe on the rising edge of ref_clk_i.
`timescale 1ns/1ps
module lin_master_model
  import motion_state_pkg::*;
(
  input wire logic ref_clk_i,
  output cmd_s cmd_o,
  output logic [POS_W-1:0] target_o,
  output logic [SEC_W-1:0] secure_o,
  output logic secure_valid_o,
  output motion_par_s ram_par_o
);
  initial begin
    cmd_o = '0;
    target_o = 16'h0000;
    secure_o = 11'h400;
    secure_valid_o = 1'b0;
    // Working memory is never rewritten while a move runs
    ram_par_o = '{vmax: 8'h3C, vmin: 8'h05, accel_shape_select: 1'b0};
  end

  // Held across one sampling edge; data inverted once released
  task automatic send(input int idx, input logic [POS_W-1:0] tgt);
    @(posedge ref_clk_i);
    #1;
    cmd_o = '0;
    cmd_o[idx] = 1'b1;
    cmd_o.any_cmd = 1'b1;
    target_o = tgt;
    @(posedge ref_clk_i);
    #1;
    cmd_o = '0;
    target_o = ~tgt;
  endtask

  task automatic load_secure(input logic [SEC_W-1:0] s);
    @(posedge ref_clk_i);
    #1;
    secure_o = s;
    secure_valid_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    secure_valid_o = 1'b0;
    secure_o = ~s;
  endtask
endmodule // lin_master_model

// file: verification/test_motion_state_priority_encoder.sv
// Self-checking bench for the operating-state sequencer.
// Assumes the master model drives commands; faults and position come here.
`timescale 1ns/1ps
module test_motion_state_priority_encoder
  import motion_state_pkg::*;
;
  localparam int K_RD = 8;
  localparam int K_WT = 7;
  localparam int K_GS = 6;
  localparam int K_DM = 5;
  localparam int K_SL = 2;
  localparam int K_ID = 0;
  logic ref_clk_i, arst_n_i, secv, permit, sleep_f, stop_f, sec_en;
  logic bf, th, sl, hiz, hold, ids, wake;
  cmd_s cmd;
  logic [POS_W-1:0] tgt, act, tpos;
  logic [SEC_W-1:0] sec;
  motion_par_s ram, dpar, apar, spar;
  logic [1:0] given;
  event_s evt;
  op_state_e state;
  int num_errors = 0;
  int checks = 0;

  lin_master_model u_master (.ref_clk_i(ref_clk_i), .cmd_o(cmd),
    .target_o(tgt), .secure_o(sec), .secure_valid_o(secv), .ram_par_o(ram));

  motion_state_priority_encoder u_dut (.ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i), .cmd_i(cmd), .cmd_target_i(tgt),
    .cmd_secure_i(sec), .cmd_secure_valid_i(secv), .ram_par_i(ram),
    .dual_par_i(dpar), .dual_par_given_i(given), .evt_i(evt),
    .actual_pos_i(act), .sleep_permit_i(permit), .state_o(state),
    .target_pos_o(tpos), .active_par_o(apar), .status_par_o(spar),
    .sleep_flag_o(sleep_f), .stop_flag_o(stop_f), .secure_en_o(sec_en),
    .bridge_fault_flag_o(bf), .thermal_flag_o(th), .step_loss_o(sl),
    .bridges_hiz_o(hiz), .hold_current_o(hold), .assign_ids_o(ids),
    .wake_reset_o(wake));

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  // Bounded wait, since decel and secure fall-back take a few cycles
  task automatic expect_state(input op_state_e exp, input int n);
    for (int i = 0; i < n && state !== exp; i++) step(1);
    chk("state", 16'(exp), 16'(state));
  endtask

  task automatic done();
    evt.motion_done = 1'b1;
    step(1);
    evt.motion_done = 1'b0;
  endtask

  task automatic print_verdict();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    #50us;
    num_errors++;
    $display("mismatch watchdog expected end seen hang");
    print_verdict();
  end

  initial begin
    arst_n_i = 1'b0;
    dpar = '{vmax: 8'hA0, vmin: 8'h11, accel_shape_select: 1'b0};
    given = 2'b01;
    evt = '0;
    act = 16'h0000;
    permit = 1'b1;
    step(12);
    chk("state", 16'(ST_STANDBY), 16'(state));
    chk("hiz", 1'b1, hiz);
    chk("secure_en", 1'b0, sec_en);
    arst_n_i = 1'b1;
    u_master.send(K_RD, 16'h0000);
    chk("state", 16'(ST_STOPPED), 16'(state));
    chk("status vmax", ram.vmax, spar.vmax);
    u_master.send(K_ID, 16'h0000);
    chk("assign_ids", 1'b1, ids);
    chk("state", 16'(ST_STOPPED), 16'(state));
    u_master.load_secure(11'h010);
    step(1);
    chk("secure_en", 1'b1, sec_en);
    u_master.load_secure(11'h400);
    step(1);
    chk("secure_en", 1'b0, sec_en);
    u_master.send(K_WT, 16'h0040);
    chk("state", 16'(ST_GOTO), 16'(state));
    chk("target", 16'h0040, tpos);
    act = 16'h0040;
    done();
    expect_state(ST_STOPPED, 3);
    chk("hold", 1'b1, hold);
    // Decelerating then forced stop, each ending in stopped
    for (int k = 0; k < 2; k++) begin
      u_master.send(K_WT, 16'h0080);
      u_master.send(4 - k, 16'h0000);
      expect_state(k ? ST_FORCED : ST_DECEL, 1);
      act = 16'h0060 + 16'(k);
      done();
      expect_state(ST_STOPPED, 3);
      chk("target", 16'h0060 + 16'(k), tpos);
      chk("stop", 1'b1, stop_f);
      step(1);
      chk("stop", 1'b0, stop_f);
    end
    u_master.send(K_WT, 16'h00A0);
    u_master.send(K_SL, 16'h0000);
    chk("sleep", 1'b1, sleep_f);
    expect_state(ST_DECEL, 1);
    act = 16'h0070;
    done();
    expect_state(ST_STOPPED, 3);
    expect_state(ST_SLEEP, 4);
    act = 16'h0000;
    u_master.send(K_RD, 16'h0000);
    chk("wake", 1'b1, wake);
    expect_state(ST_STANDBY, 2);
    chk("target", 16'h0000, tpos);
    u_master.send(K_RD, 16'h0000);
    permit = 1'b0;
    u_master.send(K_SL, 16'h0000);
    step(5);
    chk("state", 16'(ST_STOPPED), 16'(state));
    u_master.send(K_RD, 16'h0000);
    chk("sleep", 1'b0, sleep_f);
    permit = 1'b1;
    u_master.load_secure(11'h020);
    u_master.send(K_SL, 16'h0000);
    expect_state(ST_GOTO, 3);
    chk("target", 16'h0020, tpos);
    act = 16'h0020;
    done();
    expect_state(ST_SLEEP, 5);
    act = 16'h0000;
    u_master.send(K_RD, 16'h0000);
    expect_state(ST_STANDBY, 3);
    chk("secure_en", 1'b0, sec_en);
    u_master.send(K_RD, 16'h0000);
    evt.thermal_shutdown = 1'b1;
    expect_state(ST_SHUTDOWN, 3);
    chk("hiz", 1'b1, hiz);
    u_master.send(K_RD, 16'h0000);
    step(3);
    chk("state", 16'(ST_SHUTDOWN), 16'(state));
    chk("thermal", 1'b1, th);
    evt.thermal_shutdown = 1'b0;
    step(3);
    chk("state", 16'(ST_SHUTDOWN), 16'(state));
    u_master.send(K_RD, 16'h0000);
    chk("state", 16'(ST_SHUTDOWN), 16'(state));
    // The first read only clears the flags; the next one may leave shutdown
    u_master.send(K_RD, 16'h0000);
    expect_state(ST_STOPPED, 3);
    chk("hold", 1'b1, hold);
    chk("thermal", 1'b0, th);
    u_master.send(K_DM, 16'h0000);
    expect_state(ST_DUAL, 1);
    step(1);
    chk("dual vmax", dpar.vmax, apar.vmax);
    chk("dual vmin", ram.vmin, apar.vmin);
    chk("status vmax", ram.vmax, spar.vmax);
    done();
    step(1);
    chk("shape", 1'b1, apar.accel_shape_select);
    done();
    expect_state(ST_STOPPED, 3);
    chk("shape", 1'b0, apar.accel_shape_select);
    // Coil defect mid-move, then targets still taken with step loss set
    u_master.load_secure(11'h030);
    u_master.send(K_WT, 16'h0100);
    evt.electrical_defect = 1'b1;
    step(1);
    evt.electrical_defect = 1'b0;
    chk("state", 16'(ST_FORCED), 16'(state));
    chk("bridge_fault", 1'b1, bf);
    chk("step_loss", 1'b1, sl);
    act = 16'h0090;
    done();
    expect_state(ST_STOPPED, 3);
    u_master.send(K_GS, 16'h0000);
    chk("state", 16'(ST_GOTO), 16'(state));
    chk("target", 16'h0030, tpos);
    act = 16'h0030;
    done();
    expect_state(ST_STOPPED, 3);
    chk("step_loss", 1'b1, sl);
    u_master.send(K_RD, 16'h0000);
    chk("step_loss", 1'b0, sl);
    step(1);
    chk("bridge_fault", 1'b0, bf);
    // Bus timeout while moving with a secure position loaded
    u_master.send(K_WT, 16'h0200);
    evt.bus_timeout = 1'b1;
    step(1);
    evt.bus_timeout = 1'b0;
    chk("sleep", 1'b1, sleep_f);
    chk("state", 16'(ST_GOTO), 16'(state));
    chk("target", 16'h0030, tpos);
    done();
    expect_state(ST_SLEEP, 3);
    u_master.send(K_RD, 16'h0000);
    expect_state(ST_STANDBY, 3);
    u_master.send(K_RD, 16'h0000);
    expect_state(ST_GOTO, 2);
    evt.undervoltage_level_two = 1'b1;
    step(1);
    evt.undervoltage_level_two = 1'b0;
    chk("state", 16'(ST_UNDERV), 16'(state));
    act = 16'h0000;
    done();
    expect_state(ST_STOPPED, 3);
    chk("stop", 1'b0, stop_f);
    // Sleep during a dual move defers the secure target to its end
    u_master.load_secure(11'h050);
    u_master.send(K_DM, 16'h0000);
    u_master.send(K_SL, 16'h0000);
    chk("target", 16'h0000, tpos);
    done();
    step(1);
    done();
    chk("state", 16'(ST_STOPPED), 16'(state));
    chk("target", 16'h0050, tpos);
    print_verdict();
  end
endmodule // test_motion_state_priority_encoder
